// ===== rtl/block_sequencer.v
// Overview of operation
// - Host seeds block pointer; device advances it.
// - Run blocks in order until list terminator.
// - Head pointer word is never accessed.
// - Invalid terminal response sets control bit 15.
// - Skip bit bypasses message, goes next.
// - Bit 13 pulses normal interrupt when enabled.
// - Bit 12 enables polling comparison on status.
// - Bit 11 enables retry with global parameters.
// - Terminator halts after message, urgent interrupt.
// - Bit 9 means terminal-to-terminal transfer.
// - Bit 8 monitors and stores transfer data.
// - Bits 7-0 set delay; zero disables timer.
// - One delay count is sixteen microseconds.
// - At least four microseconds between messages of one run.
// - Skipped block still waits programmed delay, unless it terminates.
// - Long message simply completes, then proceeds.
// - Skip with terminator still raises urgent interrupt.
// - Skip with continue still raises normal interrupt.
// - Second command word used only for transfers.
// - Status one stored unless skipped; status two transfers.
// - Follow tail pointer to next block.
// - Mask and status overlap raises poll interrupt.
// - Block start reads control, command one, data pointer.
// - Command two fourth word; status sixth, seventh.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`include "block_sequencer_regs.vh"

module block_sequencer #(
    parameter STEP_CYCLES = `DELAY_STEP_CYCLES,
    parameter GAP_CYCLES = `MIN_GAP_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output reg mem_req,
    output reg mem_we,
    output reg [15:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    output reg msg_start,
    output reg [15:0] msg_cmd1,
    output reg [15:0] msg_cmd2,
    output reg [15:0] msg_data_ptr,
    output reg msg_rt2rt,
    output reg msg_monitor,
    output reg msg_retry_en,
    output wire [2:0] msg_retry_cfg,
    input wire msg_done,
    input wire msg_invalid,
    input wire [15:0] msg_stat1,
    input wire [15:0] msg_stat2,
    output reg normal_irq,
    output wire urgent_irq_n
);
    localparam S_IDLE = 4'h0;
    localparam S_RD_CTRL = 4'h1;
    localparam S_RD_CMD1 = 4'h2;
    localparam S_RD_DPTR = 4'h3;
    localparam S_RD_CMD2 = 4'h4;
    localparam S_DISPATCH = 4'h5;
    localparam S_WAIT_MSG = 4'h6;
    localparam S_WR_ST1 = 4'h7;
    localparam S_WR_ST2 = 4'h8;
    localparam S_WR_CTRL = 4'h9;
    localparam S_WAIT_TMR = 4'hA;
    localparam S_RD_TAIL = 4'hB;

    reg [3:0] state_q;
    reg [15:0] block_ptr_q;
    reg [15:0] ctrl_word_q;
    reg [15:0] poll_mask_q;
    reg [1:0] normal_en_q;
    reg urgent_en_q;
    reg [2:0] retry_cfg_q;
    reg urgent_q;
    reg [7:0] steps_q;
    reg [11:0] pre_q;
    reg [11:0] gap_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg start_req_q;
    reg urgent_ack_q;

    wire busy = (state_q != S_IDLE);
    wire acc_ok = hsel && hready && htrans[1];
    wire timer_idle = (steps_q == 8'h00) && (gap_q == 12'h000);
    wire poll_hit = |(poll_mask_q & msg_stat1);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign urgent_irq_n = ~urgent_q;
    assign msg_retry_cfg = retry_cfg_q;

    function [31:0] read_mux;
        input [7:0] ofs;
        begin
            case (ofs)
                `OFS_CONTROL: read_mux = {27'h0, retry_cfg_q, 2'h0};
                `OFS_BLOCK_PTR: read_mux = {16'h0000, block_ptr_q};
                `OFS_NORMAL_EN: read_mux = {30'h0, normal_en_q};
                `OFS_URGENT_EN: read_mux = {31'h0, urgent_en_q};
                `OFS_POLL_MASK: read_mux = {16'h0000, poll_mask_q};
                `OFS_STATUS: read_mux = {ctrl_word_q, 10'h000, urgent_q, busy, state_q};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // Bus slave: zero wait states, writes land in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            normal_en_q <= 2'h0;
            urgent_en_q <= 1'b0;
            poll_mask_q <= `RST_POLL_MASK;
            retry_cfg_q <= `RST_RETRY;
            start_req_q <= 1'b0;
            urgent_ack_q <= 1'b0;
        end else if (ce) begin
            start_req_q <= 1'b0;
            urgent_ack_q <= 1'b0;
            if (hready) begin
                wr_pend_q <= acc_ok && hwrite;
                wr_addr_q <= haddr[7:0];
            end
            if (acc_ok && !hwrite) begin
                hrdata <= read_mux(haddr[7:0]);
            end
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `OFS_CONTROL: begin
                        start_req_q <= hwdata[`CTL_START];
                        urgent_ack_q <= hwdata[`CTL_URGENT_ACK];
                        retry_cfg_q <= hwdata[`CTL_RETRY_HI:`CTL_RETRY_LO];
                    end
                    `OFS_NORMAL_EN: normal_en_q <= hwdata[1:0];
                    `OFS_URGENT_EN: urgent_en_q <= hwdata[`UEN_TERMINATOR];
                    `OFS_POLL_MASK: poll_mask_q <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Delay timer runs from message start; the least gap runs from message end.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            steps_q <= 8'h00;
            pre_q <= 12'h000;
            gap_q <= 12'h000;
        end else if (ce) begin
            if (state_q == S_DISPATCH) begin
                steps_q <= ctrl_word_q[`CW_DELAY_HI:0];
                pre_q <= STEP_CYCLES[11:0] - 12'h001;
            end else if (steps_q != 8'h00) begin
                if (pre_q == 12'h000) begin
                    pre_q <= STEP_CYCLES[11:0] - 12'h001;
                    steps_q <= steps_q - 8'h01;
                end else begin
                    pre_q <= pre_q - 12'h001;
                end
            end
            if (state_q == S_WAIT_MSG && msg_done) begin
                gap_q <= GAP_CYCLES[11:0];
            end else if (gap_q != 12'h000) begin
                gap_q <= gap_q - 12'h001;
            end
        end
    end

    // Block walker. The head pointer at offset zero is never addressed.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            block_ptr_q <= `RST_BLOCK_PTR;
            ctrl_word_q <= 16'h0000;
            urgent_q <= 1'b0;
            normal_irq <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 16'h0000;
            msg_start <= 1'b0;
            msg_cmd1 <= 16'h0000;
            msg_cmd2 <= 16'h0000;
            msg_data_ptr <= 16'h0000;
            msg_rt2rt <= 1'b0;
            msg_monitor <= 1'b0;
            msg_retry_en <= 1'b0;
        end else if (ce) begin
            normal_irq <= 1'b0;
            msg_start <= 1'b0;
            if (urgent_ack_q) begin
                urgent_q <= 1'b0;
            end
            if (mem_ack) begin
                mem_req <= 1'b0;
            end
            case (state_q)
                S_IDLE: begin
                    if (wr_pend_q && wr_addr_q == `OFS_BLOCK_PTR) begin
                        block_ptr_q <= hwdata[15:0];
                    end
                    if (start_req_q) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= block_ptr_q + `BLK_CTRL;
                        state_q <= S_RD_CTRL;
                    end
                end
                S_RD_CTRL: begin
                    if (mem_ack) begin
                        ctrl_word_q <= mem_rdata;
                        if (mem_rdata[`CW_CONTINUE] && normal_en_q[`NEN_CONTINUE]) begin
                            normal_irq <= 1'b1;
                        end
                        mem_req <= 1'b1;
                        mem_addr <= block_ptr_q + `BLK_CMD1;
                        state_q <= S_RD_CMD1;
                    end
                end
                S_RD_CMD1: begin
                    if (mem_ack) begin
                        msg_cmd1 <= mem_rdata;
                        mem_req <= 1'b1;
                        mem_addr <= block_ptr_q + `BLK_DPTR;
                        state_q <= S_RD_DPTR;
                    end
                end
                S_RD_DPTR: begin
                    if (mem_ack) begin
                        msg_data_ptr <= mem_rdata;
                        if (ctrl_word_q[`CW_RT2RT] && !ctrl_word_q[`CW_SKIP]) begin
                            mem_req <= 1'b1;
                            mem_addr <= block_ptr_q + `BLK_CMD2;
                            state_q <= S_RD_CMD2;
                        end else begin
                            state_q <= S_DISPATCH;
                        end
                    end
                end
                S_RD_CMD2: begin
                    if (mem_ack) begin
                        msg_cmd2 <= mem_rdata;
                        state_q <= S_DISPATCH;
                    end
                end
                S_DISPATCH: begin
                    // Starts at once; the previous block's delay and gap were waited out before its tail read.
                    if (ctrl_word_q[`CW_SKIP]) begin
                        state_q <= S_WAIT_TMR;
                    end else begin
                        msg_start <= 1'b1;
                        msg_rt2rt <= ctrl_word_q[`CW_RT2RT];
                        msg_monitor <= ctrl_word_q[`CW_RT2RT] & ctrl_word_q[`CW_MONITOR];
                        msg_retry_en <= ctrl_word_q[`CW_RETRY];
                        state_q <= S_WAIT_MSG;
                    end
                end
                S_WAIT_MSG: begin
                    if (msg_done) begin
                        if (msg_invalid) begin
                            ctrl_word_q[`CW_ERROR] <= 1'b1;
                        end
                        if (ctrl_word_q[`CW_POLL] && normal_en_q[`NEN_POLL] && poll_hit) begin
                            normal_irq <= 1'b1;
                        end
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= block_ptr_q + `BLK_STAT1;
                        mem_wdata <= msg_stat1;
                        state_q <= S_WR_ST1;
                    end
                end
                S_WR_ST1: begin
                    if (mem_ack) begin
                        if (msg_rt2rt) begin
                            mem_req <= 1'b1;
                            mem_addr <= block_ptr_q + `BLK_STAT2;
                            mem_wdata <= msg_stat2;
                            state_q <= S_WR_ST2;
                        end else if (ctrl_word_q[`CW_ERROR]) begin
                            mem_req <= 1'b1;
                            mem_addr <= block_ptr_q + `BLK_CTRL;
                            mem_wdata <= ctrl_word_q;
                            state_q <= S_WR_CTRL;
                        end else begin
                            mem_we <= 1'b0;
                            state_q <= S_WAIT_TMR;
                        end
                    end
                end
                S_WR_ST2: begin
                    if (mem_ack) begin
                        if (ctrl_word_q[`CW_ERROR]) begin
                            mem_req <= 1'b1;
                            mem_addr <= block_ptr_q + `BLK_CTRL;
                            mem_wdata <= ctrl_word_q;
                            state_q <= S_WR_CTRL;
                        end else begin
                            mem_we <= 1'b0;
                            state_q <= S_WAIT_TMR;
                        end
                    end
                end
                S_WR_CTRL: begin
                    if (mem_ack) begin
                        mem_we <= 1'b0;
                        state_q <= S_WAIT_TMR;
                    end
                end
                S_WAIT_TMR: begin
                    // A message longer than the delay finds the timer already empty.
                    if (ctrl_word_q[`CW_TERMINATOR]) begin
                        if (urgent_en_q) begin
                            urgent_q <= 1'b1;
                        end
                        state_q <= S_IDLE;
                    end else if (timer_idle) begin
                        mem_req <= 1'b1;
                        mem_addr <= block_ptr_q + `BLK_TAIL;
                        state_q <= S_RD_TAIL;
                    end
                end
                S_RD_TAIL: begin
                    if (mem_ack) begin
                        block_ptr_q <= mem_rdata;
                        mem_req <= 1'b1;
                        mem_addr <= mem_rdata + `BLK_CTRL;
                        state_q <= S_RD_CTRL;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== rtl/block_sequencer_regs.vh
`ifndef BLOCK_SEQUENCER_REGS_VH
`define BLOCK_SEQUENCER_REGS_VH

// Register byte offsets on the AHB-Lite slave.
`define OFS_CONTROL 8'h00
`define OFS_BLOCK_PTR 8'h04
`define OFS_NORMAL_EN 8'h08
`define OFS_URGENT_EN 8'h0C
`define OFS_POLL_MASK 8'h10
`define OFS_STATUS 8'h14

// Control register fields.
`define CTL_START 0
`define CTL_URGENT_ACK 1
`define CTL_RETRY_LO 2
`define CTL_RETRY_HI 4

// Interrupt enable fields.
`define NEN_CONTINUE 0
`define NEN_POLL 1
`define UEN_TERMINATOR 0

// Reset values.
`define RST_BLOCK_PTR 16'h0000
`define RST_POLL_MASK 16'h0000
`define RST_RETRY 3'h0

// Command block word offsets from the block start address.
`define BLK_CTRL 16'h0001
`define BLK_CMD1 16'h0002
`define BLK_CMD2 16'h0003
`define BLK_DPTR 16'h0004
`define BLK_STAT1 16'h0005
`define BLK_STAT2 16'h0006
`define BLK_TAIL 16'h0007

// Control word fields.
`define CW_ERROR 15
`define CW_SKIP 14
`define CW_CONTINUE 13
`define CW_POLL 12
`define CW_RETRY 11
`define CW_TERMINATOR 10
`define CW_RT2RT 9
`define CW_MONITOR 8
`define CW_DELAY_HI 7

// Timing: clock period, delay step and least gap, all in ns.
`define CLK_PERIOD_NS 4
`define DELAY_STEP_NS 16000
`define MIN_GAP_NS 4000
`define DELAY_STEP_CYCLES (`DELAY_STEP_NS / `CLK_PERIOD_NS)
`define MIN_GAP_CYCLES ((`MIN_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== tb/block_sequencer_sva.sv
module block_sequencer_sva #(
    parameter STEP_CYCLES = 4000,
    parameter GAP_CYCLES = 1000
) (
    input wire hclk,
    input wire hresetn,
    input wire [31:0] hwdata,
    input wire mem_req,
    input wire mem_we,
    input wire [15:0] mem_addr,
    input wire mem_ack,
    input wire msg_start,
    input wire msg_rt2rt,
    input wire msg_monitor,
    input wire msg_done,
    input wire normal_irq,
    input wire urgent_irq_n
);
    // Cycles since the last message ended; it saturates so it never wraps in long idles.
    integer gap_q;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            gap_q <= GAP_CYCLES;
        else if (msg_done)
            gap_q <= 0;
        else if (gap_q < GAP_CYCLES)
            gap_q <= gap_q + 1;
    end
    start_pulse_a: assert property (msg_start |=> !msg_start)
        else $error("Message start lasted more than one cycle.");
    req_held_a: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("Memory request changed before its acknowledge.");
    status_due_a: assert property (msg_done |-> ##[1:40] (mem_req && mem_we))
        else $error("No status write after the message ended.");
    gap_kept_a: assert property (msg_start |-> gap_q >= GAP_CYCLES)
        else $error("Message started inside the least gap.");
    urgent_held_a: assert property (!urgent_irq_n && !hwdata[1] |=> !urgent_irq_n)
        else $error("Urgent interrupt cleared without acknowledge.");
    normal_cause_a: assert property (normal_irq |-> $past(mem_ack) || $past(mem_ack, 2)
        || $past(msg_done) || $past(msg_done, 2))
        else $error("Normal interrupt without a block fetch or message end.");
    monitor_pair_a: assert property (msg_start && msg_monitor |-> msg_rt2rt)
        else $error("Monitoring flagged on a single terminal message.");
    normal_pulse_a: assert property (normal_irq |=> !normal_irq)
        else $error("Normal interrupt lasted more than one cycle.");
    cover property (msg_start && msg_monitor);
    cover property ($fell(urgent_irq_n));
    cover property (normal_irq);
endmodule
bind block_sequencer block_sequencer_sva #(.STEP_CYCLES(STEP_CYCLES), .GAP_CYCLES(GAP_CYCLES))
    i_sva (.hclk, .hresetn, .hwdata, .mem_req, .mem_we, .mem_addr, .mem_ack, .msg_start,
    .msg_rt2rt, .msg_monitor, .msg_done, .normal_irq, .urgent_irq_n);

// ===== tb/rt_bus_model.sv
module rt_bus_model (
    input wire logic hclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack = 1'b0,
    output logic [15:0] mem_rdata = 16'hA5A5,
    input wire logic msg_start,
    output logic msg_done = 1'b0,
    output logic msg_invalid = 1'b0,
    output logic [15:0] msg_stat1 = 16'hA5A5,
    output logic [15:0] msg_stat2 = 16'h5A5A,
    input wire logic [7:0] msg_len,
    input wire logic bad,
    input wire logic [15:0] stat_a,
    input wire logic [15:0] stat_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:4095];
    bit rd_seen [0:4095];
    bit wr_seen [0:4095];
    logic [7:0] cnt = 8'h00;
    // Every word costs one wait state; idle lines toggle so no stale value looks valid.
    always @(posedge hclk) begin
        mem_ack <= mem_req && !mem_ack;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && !mem_we) begin
            mem_rdata <= mem[mem_addr[11:0]];
            rd_seen[mem_addr[11:0]] <= 1'b1;
        end
        if (mem_req && mem_ack && mem_we) begin
            mem[mem_addr[11:0]] <= mem_wdata;
            wr_seen[mem_addr[11:0]] <= 1'b1;
        end
        if (msg_start)
            cnt <= msg_len;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        msg_done <= cnt == 8'h01;
        msg_invalid <= (cnt == 8'h01) ? bad : !msg_invalid;
        msg_stat1 <= (cnt == 8'h01) ? stat_a : ~msg_stat1;
        msg_stat2 <= (cnt == 8'h01) ? stat_b : ~msg_stat2;
    end
endmodule

// ===== tb/tb_top.sv
`include "block_sequencer_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 8;
    localparam int GAP = 4;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, normal_irq, urgent_irq_n, p_bad;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize, msg_retry_cfg, flags;
    logic mem_req, mem_we, mem_ack, msg_start, msg_rt2rt, msg_monitor, msg_retry_en;
    logic msg_done, msg_invalid;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, msg_cmd1, msg_cmd2, msg_data_ptr;
    logic [15:0] msg_stat1, msg_stat2, p_s1, p_s2, c1, c2, dp;
    logic [7:0] p_len;
    int failures = 0, num_checks = 0, nirq = 0, cyc = 0;
    int t_st[$], t_dn[$];
    block_sequencer #(.STEP_CYCLES(STEP), .GAP_CYCLES(GAP)) i_dut (
        .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .msg_start, .msg_cmd1, .msg_cmd2, .msg_data_ptr,
        .msg_rt2rt, .msg_monitor, .msg_retry_en, .msg_retry_cfg, .msg_done, .msg_invalid,
        .msg_stat1, .msg_stat2, .normal_irq, .urgent_irq_n);
    rt_bus_model i_rt (
        .hclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .msg_start,
        .msg_done, .msg_invalid, .msg_stat1, .msg_stat2, .msg_len(p_len), .bad(p_bad),
        .stat_a(p_s1), .stat_b(p_s2));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (normal_irq === 1'b1)
            nirq++;
        if (msg_done === 1'b1)
            t_dn.push_back(cyc);
        if (msg_start === 1'b1) begin
            if (t_st.size() == 0)
                {c1, c2, dp, flags} = {msg_cmd1, msg_cmd2, msg_data_ptr, msg_rt2rt,
                    msg_monitor, msg_retry_en};
            t_st.push_back(cyc);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("Checks made %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h000000, a};
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (n >= 50) begin
                failures++;
                complete_run();
            end
            {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        end
        q = hrdata;
    endtask
    // Polling the busy flag, for up to 300 status reads, keeps the bench free of a fixed wait for the run.
    task automatic wait_idle;
        for (int i = 0; i < 300; i++) begin
            xfer(1'b0, `OFS_STATUS, 32'h0);
            if (q[4] === 1'b0)
                return;
        end
        failures++;
        complete_run();
    endtask
    task automatic blk(input int b, input logic [15:0] cw, w2, w3, w4, tl);
        {i_rt.mem[b + 1], i_rt.mem[b + 2], i_rt.mem[b + 3]} = {cw, w2, w3};
        {i_rt.mem[b + 4], i_rt.mem[b + 7]} = {w4, tl};
    endtask
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = {37'h0, 32'h0, 3'h2};
        {p_bad, p_len, p_s1, p_s2} = {1'b1, 8'h03, 16'h0004, 16'h5555};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, `OFS_BLOCK_PTR, 32'h0);
        check(q, 32'h0);
        xfer(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        xfer(1'b1, `OFS_NORMAL_EN, 32'h3);
        xfer(1'b1, `OFS_URGENT_EN, 32'h1);
        xfer(1'b1, `OFS_POLL_MASK, 32'h4);
        xfer(1'b1, `OFS_BLOCK_PTR, 32'h100);
        blk(16'h0100, 16'h3B03, 16'h1111, 16'h2222, 16'h0400, 16'h0200);
        blk(16'h0200, 16'h6002, 16'h7777, 16'h7778, 16'h0500, 16'h0300);
        blk(16'h0300, 16'h0400, 16'h8888, 16'hDEAD, 16'h0600, 16'h0100);
        xfer(1'b1, `OFS_CONTROL, 32'h0000000D);
        wait_idle();
        check(msg_retry_cfg, 3'h3);
        check({31'h0, hresp}, 32'h0);
        check(t_st.size(), 2);
        check({c1, c2}, 32'h11112222);
        check({dp, 13'h0, flags}, 32'h04000007);
        check(t_st[1] - t_st[0] >= 5 * STEP, 1);
        check(nirq, 3);
        check(urgent_irq_n, 1'b0);
        check({i_rt.mem[16'h105], i_rt.mem[16'h106]}, 32'h00045555);
        check({i_rt.mem[16'h101], i_rt.mem[16'h301]}, 32'hBB038400);
        check({i_rt.rd_seen[16'h100], i_rt.rd_seen[16'h200], i_rt.rd_seen[16'h300]}, 0);
        check({i_rt.rd_seen[16'h103], i_rt.rd_seen[16'h303]}, 2'h2);
        check({i_rt.wr_seen[16'h205], i_rt.wr_seen[16'h306]}, 2'h0);
        xfer(1'b0, `OFS_BLOCK_PTR, 32'h0);
        check(q, 32'h300);
        xfer(1'b1, `OFS_CONTROL, 32'h2);
        blk(16'h0100, 16'h0004, 16'h3333, 16'h0000, 16'h0500, 16'h0200);
        blk(16'h0200, 16'h0000, 16'h4444, 16'h0000, 16'h0600, 16'h0300);
        i_rt.mem[16'h301] = 16'h4400;
        {p_bad, p_len, nirq} <= {1'b0, 8'h3C, 32'h0};
        t_st.delete();
        t_dn.delete();
        xfer(1'b1, `OFS_BLOCK_PTR, 32'h100);
        check(urgent_irq_n, 1'b1);
        xfer(1'b1, `OFS_CONTROL, 32'h1);
        wait_idle();
        check(t_st.size(), 2);
        check(t_st[1] - t_dn[0] >= GAP && t_st[1] - t_dn[0] <= GAP + 20, 1);
        check({urgent_irq_n, nirq[3:0]}, 5'h00);
        check({i_rt.mem[16'h201], 15'h0, i_rt.wr_seen[16'h206]}, 32'h0);
        complete_run();
    end
endmodule
